// File: logic/radio_device_end.sv
`timescale 1ns/1ps
module radio_device_end (
	input  wire logic       sys_clk_in,
	input  wire logic       srst_in,
	input  wire logic [5:0] event_level_in,
	input  wire logic [7:0] rx_byte_in,
	input  wire logic       rx_byte_valid_in,
	input  wire logic       tx_byte_request_in,
	input  wire logic       deep_sleep_in,
	output logic [7:0]      tx_byte_out,
	output logic            tx_byte_valid_out,
	output logic            symbol_tick_out,
	output logic [2:0]      radio_mode_out,
	output logic [7:0]      rate_mantissa_out,
	output logic [3:0]      rate_exponent_out,
	radio_link_if.device    link
);
	typedef struct packed {
		logic [7:0]            flags;
		logic [7:0]            mask;
		logic [7:0]            cond_prev;
		logic [7:0]            buf_data;
		logic                  buf_full;
		radio_pkg::radio_mode_t mode;
		logic [7:0]            cfg3;
		logic [7:0]            cfg4;
		logic [27:0]           acc;
		logic                  tick;
		logic [7:0]            rdata;
		logic                  event_pulse;
		logic                  byte_ready;
		logic [7:0]            tx_data;
		logic                  tx_valid;
	} dev_state_t;

	dev_state_t  s_q;
	dev_state_t  s_d;
	logic [7:0]  cond;
	logic [7:0]  rise;
	logic        overrun_evt;
	logic        underrun_evt;
	logic        wr_byte;
	logic        rd_byte;
	logic [23:0] rate_step;
	logic [28:0] acc_sum;

	assign wr_byte = link.wr && (link.addr == radio_pkg::BYTE_PORT_OFS);
	assign rd_byte = link.rd && (link.addr == radio_pkg::BYTE_PORT_OFS);
	// Step per clock is (256 + m) << e; a carry out of 28 bits is one symbol
	assign rate_step = 24'({15'h0000, radio_pkg::RATE_BASE + {1'b0, s_q.cfg3}} << s_q.cfg4[3:0]);
	assign acc_sum = {1'b0, s_q.acc} + {5'h00, rate_step};

	always_comb begin
		s_d = s_q;
		overrun_evt = 1'b0;
		underrun_evt = 1'b0;
		s_d.tx_valid = 1'b0;
		// One rate feeds both directions, so the modem sees a single symbol tick
		s_d.tick = 1'b0;
		if (s_q.mode != radio_pkg::MODE_IDLE) begin
			s_d.acc = acc_sum[radio_pkg::RATE_SHIFT-1:0];
			s_d.tick = acc_sum[radio_pkg::RATE_SHIFT];
		end else begin
			s_d.acc = 28'h0000000;
		end

		// Byte buffer: a read frees it before a new byte lands in the same cycle
		if (rd_byte) begin
			s_d.buf_full = 1'b0;
		end
		if (wr_byte && s_q.mode == radio_pkg::MODE_TX) begin
			s_d.buf_data = link.wdata;
			s_d.buf_full = 1'b1;
		end
		case (s_q.mode)
			radio_pkg::MODE_RX: begin
				if (rx_byte_valid_in) begin
					if (s_d.buf_full) begin
						overrun_evt = 1'b1;
						s_d.mode = radio_pkg::MODE_RX_OVERRUN;
					end else begin
						s_d.buf_data = rx_byte_in;
						s_d.buf_full = 1'b1;
					end
				end
			end
			radio_pkg::MODE_TX: begin
				if (tx_byte_request_in) begin
					if (s_d.buf_full) begin
						s_d.tx_data = s_d.buf_data;
						s_d.tx_valid = 1'b1;
						s_d.buf_full = 1'b0;
					end else begin
						underrun_evt = 1'b1;
						s_d.mode = radio_pkg::MODE_TX_UNDERRUN;
					end
				end
			end
			// Overrun and underrun ignore further bytes until idle
			radio_pkg::MODE_RX_OVERRUN: ;
			radio_pkg::MODE_TX_UNDERRUN: ;
			default: ;
		endcase

		// Content is lost in deep sleep; treat the buffer as empty on return
		if (deep_sleep_in) begin
			s_d.buf_full = 1'b0;
		end

		if (link.wr) begin
			case (link.addr)
				radio_pkg::RADIO_MASK_OFS: s_d.mask = link.wdata;
				radio_pkg::MODEM_CFG3_OFS: s_d.cfg3 = link.wdata;
				radio_pkg::MODEM_CFG4_OFS: s_d.cfg4 = link.wdata;
				radio_pkg::EVENT_FLAGS_OFS: s_d.flags = s_q.flags & link.wdata;
				radio_pkg::STROBE_REG_OFS: begin
					case (link.wdata)
						radio_pkg::IDLE_STROBE_CODE: begin
							s_d.mode = radio_pkg::MODE_IDLE;
							s_d.buf_full = 1'b0;
						end
						radio_pkg::RX_STROBE_CODE: begin
							if (s_q.mode == radio_pkg::MODE_IDLE) begin
								s_d.mode = radio_pkg::MODE_RX;
								s_d.buf_full = 1'b0;
							end
						end
						radio_pkg::TX_STROBE_CODE: begin
							if (s_q.mode == radio_pkg::MODE_IDLE || s_q.mode == radio_pkg::MODE_RX) begin
								s_d.mode = radio_pkg::MODE_TX;
								s_d.buf_full = 1'b0;
							end
						end
						default: ;
					endcase
				end
				default: ;
			endcase
		end

		// Internal events are single-cycle, so their edge is the event itself
		cond = {underrun_evt, overrun_evt, event_level_in};
		cond[radio_pkg::PKT_DONE_BIT] = event_level_in[radio_pkg::PKT_DONE_BIT]
			| overrun_evt | underrun_evt;
		rise = cond & ~s_q.cond_prev;
		s_d.cond_prev = cond;
		// Set is applied after the clear so no event is lost
		s_d.flags = s_d.flags | rise;
		s_d.event_pulse = |(rise & s_q.mask);

		s_d.rdata = 8'h00;
		if (link.rd) begin
			case (link.addr)
				radio_pkg::RADIO_MASK_OFS: s_d.rdata = s_q.mask;
				radio_pkg::EVENT_FLAGS_OFS: s_d.rdata = s_q.flags;
				radio_pkg::BYTE_PORT_OFS: s_d.rdata = s_q.buf_data;
				radio_pkg::MODEM_CFG3_OFS: s_d.rdata = s_q.cfg3;
				radio_pkg::MODEM_CFG4_OFS: s_d.rdata = s_q.cfg4;
				radio_pkg::STROBE_REG_OFS: s_d.rdata = {5'h00, s_q.mode};
				default: s_d.rdata = 8'h00;
			endcase
		end

		s_d.byte_ready = (s_d.mode == radio_pkg::MODE_RX && s_d.buf_full)
			|| (s_d.mode == radio_pkg::MODE_TX && !s_d.buf_full);
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			s_q <= '0;
			s_q.flags <= radio_pkg::FLAGS_RESET;
			s_q.mask <= radio_pkg::MASK_RESET;
			s_q.cfg3 <= radio_pkg::CFG_RESET;
			s_q.cfg4 <= radio_pkg::CFG_RESET;
			s_q.mode <= radio_pkg::MODE_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign link.rdata = s_q.rdata;
	assign link.event_pulse = s_q.event_pulse;
	assign link.byte_ready = s_q.byte_ready;
	assign tx_byte_out = s_q.tx_data;
	assign tx_byte_valid_out = s_q.tx_valid;
	assign symbol_tick_out = s_q.tick;
	assign radio_mode_out = s_q.mode;
	assign rate_mantissa_out = s_q.cfg3;
	assign rate_exponent_out = s_q.cfg4[3:0];
endmodule // radio_device_end

// File: logic/radio_pkg.sv
package radio_pkg;
	// Device register offsets on the link
	localparam logic [7:0] RADIO_MASK_OFS   = 8'h91;
	localparam logic [7:0] EVENT_FLAGS_OFS  = 8'he9;
	localparam logic [7:0] BYTE_PORT_OFS    = 8'hd9;
	localparam logic [7:0] STROBE_REG_OFS   = 8'he1;
	localparam logic [7:0] MODEM_CFG3_OFS   = 8'hdc;
	localparam logic [7:0] MODEM_CFG4_OFS   = 8'hdd;
	localparam logic [7:0] FLAGS_RESET      = 8'h00;
	localparam logic [7:0] MASK_RESET       = 8'h00;
	localparam logic [7:0] CFG_RESET        = 8'h00;
	// Event bit positions
	localparam int TX_UNDERRUN_BIT = 7;
	localparam int RX_OVERRUN_BIT  = 6;
	localparam int RX_EXPIRY_BIT   = 5;
	localparam int PKT_DONE_BIT    = 4;
	// Strobe codes
	localparam logic [7:0] RX_STROBE_CODE   = 8'h02;
	localparam logic [7:0] TX_STROBE_CODE   = 8'h03;
	localparam logic [7:0] IDLE_STROBE_CODE = 8'h04;
	// Symbol rate: (RATE_BASE + m) * 2^e / 2^RATE_SHIFT * fref
	localparam logic [8:0] RATE_BASE  = 9'h100;
	localparam int         RATE_SHIFT = 28;
	// Host-side software registers
	localparam logic [2:0] HOST_CTRL_OFS   = 3'h0;
	localparam logic [2:0] HOST_STATUS_OFS = 3'h1;
	localparam logic [2:0] HOST_LADDR_OFS  = 3'h2;
	localparam logic [2:0] HOST_LWRITE_OFS = 3'h3;
	localparam logic [2:0] HOST_LREAD_OFS  = 3'h4;
	localparam logic [2:0] HOST_LDATA_OFS  = 3'h5;
	localparam logic [2:0] HOST_STROBE_OFS = 3'h6;
	localparam int COMBINED_BIT = 0;
	localparam int BYTE_BIT     = 1;

	typedef enum logic [2:0] {
		MODE_IDLE      = 3'b000,
		MODE_RX        = 3'b001,
		MODE_TX        = 3'b010,
		MODE_RX_OVERRUN = 3'b011,
		MODE_TX_UNDERRUN = 3'b100
	} radio_mode_t;
endpackage

// File: logic/radio_link_if.sv
`timescale 1ns/1ps
interface radio_link_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       event_pulse;
	logic       byte_ready;

	modport device (
		input  addr,
		input  wdata,
		input  wr,
		input  rd,
		output rdata,
		output event_pulse,
		output byte_ready
	);
	modport host (
		output addr,
		output wdata,
		output wr,
		output rd,
		input  rdata,
		input  event_pulse,
		input  byte_ready
	);
endinterface

// File: logic/radio_host_end.sv
`timescale 1ns/1ps
module radio_host_end (
	input  wire logic       sys_clk_in,
	input  wire logic       srst_in,
	input  wire logic [2:0] sw_addr_in,
	input  wire logic [7:0] sw_wdata_in,
	input  wire logic       sw_wr_in,
	input  wire logic       sw_rd_in,
	output logic [7:0]      sw_rdata_out,
	output logic            radio_irq_out,
	output logic            byte_irq_out,
	radio_link_if.host      link
);
	typedef struct packed {
		logic [1:0] enables;
		logic [1:0] flags;
		logic       ready_prev;
		logic [7:0] laddr;
		logic [7:0] link_addr;
		logic [7:0] link_wdata;
		logic       link_wr;
		logic       link_rd;
		logic       rd_pend;
		logic [7:0] ldata;
		logic [7:0] sw_rdata;
		logic       radio_irq;
		logic       byte_irq;
	} host_state_t;

	host_state_t s_q;
	host_state_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.link_wr = 1'b0;
		s_d.link_rd = 1'b0;
		s_d.rd_pend = s_q.link_rd;
		s_d.ready_prev = link.byte_ready;
		if (s_q.rd_pend) begin
			s_d.ldata = link.rdata;
		end
		if (sw_wr_in) begin
			case (sw_addr_in)
				radio_pkg::HOST_CTRL_OFS: s_d.enables = sw_wdata_in[1:0];
				radio_pkg::HOST_STATUS_OFS: s_d.flags = s_q.flags & sw_wdata_in[1:0];
				radio_pkg::HOST_LADDR_OFS: s_d.laddr = sw_wdata_in;
				radio_pkg::HOST_LWRITE_OFS: begin
					s_d.link_addr = s_q.laddr;
					s_d.link_wdata = sw_wdata_in;
					s_d.link_wr = 1'b1;
				end
				radio_pkg::HOST_LREAD_OFS: begin
					s_d.link_addr = s_q.laddr;
					s_d.link_rd = 1'b1;
				end
				radio_pkg::HOST_STROBE_OFS: begin
					// Idle code leaves overrun and underrun; transmit code starts a send from idle or receive only
					s_d.link_addr = radio_pkg::STROBE_REG_OFS;
					s_d.link_wdata = sw_wdata_in;
					s_d.link_wr = 1'b1;
				end
				default: ;
			endcase
		end
		// Set wins over a software clear in the same cycle
		if (link.event_pulse) begin
			s_d.flags[radio_pkg::COMBINED_BIT] = 1'b1;
		end
		if (link.byte_ready && !s_q.ready_prev) begin
			s_d.flags[radio_pkg::BYTE_BIT] = 1'b1;
		end
		s_d.radio_irq = s_d.flags[radio_pkg::COMBINED_BIT] && s_d.enables[radio_pkg::COMBINED_BIT];
		s_d.byte_irq = s_d.flags[radio_pkg::BYTE_BIT] && s_d.enables[radio_pkg::BYTE_BIT];
		s_d.sw_rdata = 8'h00;
		if (sw_rd_in) begin
			case (sw_addr_in)
				radio_pkg::HOST_CTRL_OFS: s_d.sw_rdata = {6'h00, s_q.enables};
				radio_pkg::HOST_STATUS_OFS: s_d.sw_rdata = {6'h00, s_q.flags};
				radio_pkg::HOST_LADDR_OFS: s_d.sw_rdata = s_q.laddr;
				radio_pkg::HOST_LDATA_OFS: s_d.sw_rdata = s_q.ldata;
				default: s_d.sw_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign link.addr = s_q.link_addr;
	assign link.wdata = s_q.link_wdata;
	assign link.wr = s_q.link_wr;
	assign link.rd = s_q.link_rd;
	assign sw_rdata_out = s_q.sw_rdata;
	assign radio_irq_out = s_q.radio_irq;
	assign byte_irq_out = s_q.byte_irq;
endmodule // radio_host_end

// File: verif/radio_link_props.sv
`timescale 1ns/1ps
module radio_link_props (
	input wire logic       sys_clk_in,
	input wire logic       srst_in,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       event_pulse,
	input wire logic       byte_ready
);
	logic [7:0] mask_q;
	logic [7:0] mask_d;
	always_comb begin
		mask_d = mask_q;
		if (wr && addr == 8'h91) begin
			mask_d = wdata;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			mask_q <= 8'h00;
		end else begin
			mask_q <= mask_d;
		end
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);
	chk_strobe_excl: assert property (!(wr && rd))
		else $error("link read and write together");
	chk_rdata_quiet: assert property (!rd |=> rdata == 8'h00)
		else $error("read data without a read");
	chk_unmapped_zero: assert property (rd && !(addr inside {8'h91, 8'he9, 8'hd9, 8'he1,
		8'hdc, 8'hdd}) |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_mask_readback: assert property ((wr && addr == 8'h91) ##1 (rd && addr == 8'h91)
		|=> rdata == $past(wdata, 2))
		else $error("mask readback differs");
	chk_rate_readback: assert property ((wr && addr == 8'hdc) ##1 (rd && addr == 8'hdc)
		|=> rdata == $past(wdata, 2))
		else $error("mantissa readback differs");
	chk_idle_mode: assert property ((wr && addr == 8'he1 && wdata == 8'h04) ##1
		(rd && addr == 8'he1) |=> rdata == 8'h00)
		else $error("idle strobe did not idle");
	chk_idle_ready: assert property (wr && addr == 8'he1 && wdata == 8'h04 |=> !byte_ready)
		else $error("byte ready after idle");
	chk_pulse_masked: assert property (event_pulse |-> $past(mask_q) != 8'h00)
		else $error("event pulse with mask clear");
endmodule // radio_link_props

// File: verif/radio_event_and_byte_port_tb_top.sv
`timescale 1ns/1ps
module radio_event_and_byte_port_tb_top;
	logic       clk, srst, swr, srd, rv, tr, ds;
	logic [2:0] sa, md;
	logic [7:0] sd, rb, q, txb, mo, r;
	logic [5:0] ev;
	logic [3:0] eo;
	logic       sym, txv, rirq, birq;
	int         fails, checks_done;
	int         m_mask, m_flags, m_comb, m_mode, prev, v, m, e, cnt, rise;
	logic [7:0] rxq[$];
	longint     step;
	radio_link_if link_bus ();
	radio_host_end u_radio_host_end (.sys_clk_in(clk), .srst_in(srst), .sw_addr_in(sa),
		.sw_wdata_in(sd), .sw_wr_in(swr), .sw_rd_in(srd), .sw_rdata_out(q),
		.radio_irq_out(rirq), .byte_irq_out(birq), .link(link_bus));
	radio_device_end u_radio_device_end (.sys_clk_in(clk), .srst_in(srst), .event_level_in(ev),
		.rx_byte_in(rb), .rx_byte_valid_in(rv), .tx_byte_request_in(tr), .deep_sleep_in(ds),
		.tx_byte_out(txb), .tx_byte_valid_out(txv), .symbol_tick_out(sym),
		.radio_mode_out(md), .rate_mantissa_out(mo), .rate_exponent_out(eo), .link(link_bus));
	radio_link_props u_props (.sys_clk_in(clk), .srst_in(srst), .addr(link_bus.addr),
		.wdata(link_bus.wdata), .wr(link_bus.wr), .rd(link_bus.rd), .rdata(link_bus.rdata),
		.event_pulse(link_bus.event_pulse), .byte_ready(link_bus.byte_ready));
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			fails++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic sw(input logic [2:0] a, input logic [7:0] d);
		sa <= a;
		sd <= d;
		swr <= 1;
		@(posedge clk);
		swr <= 0;
		@(posedge clk);
	endtask
	// Two software writes with no gap, so the link sees write then read back to back
	task automatic sw2(input logic [2:0] a1, input logic [7:0] d1, input logic [2:0] a2);
		sa <= a1;
		sd <= d1;
		swr <= 1;
		@(posedge clk);
		sa <= a2;
		sd <= 8'h00;
		@(posedge clk);
		swr <= 0;
		@(posedge clk);
	endtask
	task automatic rds(input logic [2:0] a, output logic [7:0] d);
		sa <= a;
		srd <= 1;
		@(posedge clk);
		srd <= 0;
		#1;
		d = q;
		@(posedge clk);
	endtask
	task automatic lw(input logic [7:0] a, input logic [7:0] d);
		sw(3'h2, a);
		sw(3'h3, d);
	endtask
	// Link data lands in the host two edges after the link read strobe
	task automatic lr(input logic [7:0] a, output logic [7:0] d);
		sw(3'h2, a);
		sw(3'h4, 8'h00);
		cyc(1);
		rds(3'h5, d);
	endtask
	task automatic lwr(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
		sw(3'h2, a);
		sw2(3'h3, wd, 3'h4);
		cyc(1);
		rds(3'h5, d);
	endtask
	task automatic idle_rb(output logic [7:0] d);
		sw(3'h2, 8'he1);
		sw2(3'h6, 8'h04, 3'h4);
		cyc(1);
		rds(3'h5, d);
		m_mode = 0;
		rxq.delete();
	endtask
	task automatic push(input logic [7:0] b);
		rb <= b;
		rv <= 1;
		@(posedge clk);
		rv <= 0;
		@(posedge clk);
		if (m_mode == 1) begin
			if (rxq.size() > 0) begin
				m_mode = 3;
				m_flags = m_flags | 8'h50;
			end else begin
				rxq.push_back(b);
			end
		end
	endtask
	task automatic pulse_tr(input logic ve, input logic [7:0] b);
		tr <= 1;
		@(posedge clk);
		tr <= 0;
		#1;
		chk("tx_valid", {7'h00, ve}, {7'h00, txv});
		if (ve) begin
			chk("tx_byte", b, txb);
		end
		@(posedge clk);
	endtask
	task automatic wait_birq();
		int i;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			#1;
			if (birq === 1'b1) break;
		end
		if (birq !== 1'b1) begin
			$display("wrong value byte_irq expected 1 seen %b", birq);
			fails++;
			print_verdict();
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#4ms;
		fails++;
		print_verdict();
	end
	initial begin
		{swr, srd, rv, tr, ds, sa, sd, rb, ev} = '0;
		srst = 1;
		void'($urandom(32'hbd12));
		{m_mask, m_flags, m_comb, m_mode, prev} = '0;
		cyc(4);
		srst <= 0;
		@(posedge clk);
		lr(8'h91, r);
		chk("mask_reset", 8'h00, r);
		lr(8'he9, r);
		chk("flags_reset", 8'h00, r);
		m_mask = $urandom & 255;
		lwr(8'h91, m_mask[7:0], r);
		chk("mask", m_mask[7:0], r);
		sw(3'h0, 8'h03);
		rds(3'h0, r);
		chk("host_ctrl", 8'h03, r);
		// Random event levels; flags and the combined flag follow rising edges only
		repeat (4) begin
			v = $urandom & 63;
			ev <= v[5:0];
			cyc(3);
			rise = v & ~prev & 63;
			m_flags = m_flags | rise;
			if ((rise & m_mask) != 0) m_comb = 1;
			prev = v;
		end
		lr(8'he9, r);
		chk("flags", m_flags[7:0], r);
		chk("radio_irq", m_comb[7:0], {7'h00, rirq});
		rds(3'h1, r);
		chk("host_status", m_comb[7:0], r);
		lw(8'he9, 8'h00);
		m_flags = 0;
		lr(8'he9, r);
		chk("flags_held_level", 8'h00, r);
		ev <= 6'h00;
		cyc(2);
		// Clear of all flags and a new event meet at one device edge
		sw(3'h2, 8'he9);
		sa <= 3'h3;
		sd <= 8'h00;
		swr <= 1;
		@(posedge clk);
		swr <= 0;
		ev <= 6'h01;
		@(posedge clk);
		m_flags = 1;
		lr(8'he9, r);
		chk("set_beats_clear", m_flags[7:0], r);
		ev <= 6'h00;
		lw(8'he9, 8'h00);
		m_flags = 0;
		sw(3'h1, 8'h00);
		// Transmit: strobe, wait for room, clear, write, then run dry
		sw(3'h6, 8'h03);
		m_mode = 2;
		wait_birq();
		sw(3'h1, 8'h00);
		v = $urandom & 255;
		lw(8'hd9, v[7:0]);
		pulse_tr(1'b1, v[7:0]);
		pulse_tr(1'b0, 8'h00);
		m_mode = 4;
		m_flags = 8'h90;
		chk("mode_underrun", m_mode[7:0], {5'h00, md});
		lr(8'he9, r);
		chk("flags_underrun", m_flags[7:0], r);
		idle_rb(r);
		chk("mode_idle", 8'h00, r);
		lw(8'he9, 8'h00);
		m_flags = 0;
		sw(3'h1, 8'h00);
		// Receive: one byte read back, then two unread bytes overrun
		sw(3'h6, 8'h02);
		m_mode = 1;
		push($urandom & 255);
		wait_birq();
		lr(8'hd9, r);
		chk("rx_byte", rxq.pop_front(), r);
		push($urandom & 255);
		push($urandom & 255);
		chk("mode_overrun", m_mode[7:0], {5'h00, md});
		push($urandom & 255);
		chk("mode_persists", m_mode[7:0], {5'h00, md});
		lr(8'he9, r);
		chk("flags_overrun", m_flags[7:0], r);
		idle_rb(r);
		chk("mode_idle_rx", 8'h00, r);
		// Deep sleep empties the buffer, so the next byte is no overrun
		sw(3'h6, 8'h02);
		m_mode = 1;
		push($urandom & 255);
		ds <= 1;
		@(posedge clk);
		ds <= 0;
		@(posedge clk);
		rxq.delete();
		push($urandom & 255);
		chk("mode_after_sleep", m_mode[7:0], {5'h00, md});
		lr(8'hd9, r);
		chk("byte_after_sleep", rxq.pop_front(), r);
		idle_rb(r);
		// Rate: ticks over a fixed window follow the mantissa and exponent formula
		m = $urandom & 255;
		e = 12 + ($urandom % 4);
		lwr(8'hdc, m[7:0], r);
		chk("mantissa", m[7:0], r);
		lwr(8'hdd, e[7:0], r);
		chk("exponent", e[7:0], r);
		chk("mantissa_out", m[7:0], mo);
		chk("exponent_out", e[7:0], {4'h0, eo});
		sw(3'h6, 8'h02);
		cnt = 0;
		repeat (2000) begin
			@(posedge clk);
			#1;
			if (sym === 1'b1) cnt++;
		end
		step = longint'(256 + m) << e;
		chk("symbol_ticks", 8'((2000 * step) >> 28), cnt[7:0]);
		idle_rb(r);
		// Reset in mid-run clears everything
		lw(8'h91, 8'h5a);
		srst <= 1;
		cyc(4);
		srst <= 0;
		@(posedge clk);
		#1;
		chk("rdata_after_reset", 8'h00, q);
		chk("irq_after_reset", 8'h00, {6'h00, rirq, birq});
		chk("mode_after_reset", 8'h00, {4'h0, txv, md});
		@(posedge clk);
		lr(8'h91, r);
		chk("mask_after_reset", 8'h00, r);
		lr(8'he9, r);
		chk("flags_after_reset", 8'h00, r);
		print_verdict();
	end
endmodule // radio_event_and_byte_port_tb_top
